// File: testbench/rvsup_props.sv
/*
  Concurrent checks on the ports of the reset and voltage supervisor.
  Assumes the bench keeps power_on_trip_in low and starts in Fast mode.
*/
`timescale 1ns/1ps
module rvsup_props #(
  parameter int unsigned POR_WARMUP_CYCLES = 20,
  parameter logic [13:0] ROM_LAST_ADDR = 14'h3fff
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input rvsup_pkg::rvsup_mode_t cpu_mode_in,
  input wire logic rom_read_out,
  input wire logic [13:0] rom_addr_out,
  input wire logic [7:0] rom_data_in,
  input wire logic chip_reset_out,
  input rvsup_pkg::rvsup_supply_t supply_ctl_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // Helper logic
  logic [31:0] por_cnt_q;
  logic last_rd_q;
  logic [7:0] cfg_q;
  wire sw_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h25c && !chip_reset_out;
  wire low_pwr = cpu_mode_in == rvsup_pkg::RVSUP_HALT || cpu_mode_in == rvsup_pkg::RVSUP_STOP;
  wire not_run = cpu_mode_in != rvsup_pkg::RVSUP_FAST && cpu_mode_in != rvsup_pkg::RVSUP_SLOW;
  always_ff @(posedge clock_in) begin
    por_cnt_q <= sys_rst_in ? 32'h0000_0000 : (por_cnt_q == 32'hffff_ffff ? por_cnt_q : por_cnt_q + 32'h0000_0001);
    last_rd_q <= rom_read_out && rom_addr_out == ROM_LAST_ADDR;
    if (last_rd_q) begin
      cfg_q <= rom_data_in;
    end
  end
  // ==========================================================
  // Assertions
  chk_warmup_hold: assert property ((por_cnt_q < POR_WARMUP_CYCLES) |-> chip_reset_out)
    else $error("chip reset released during warm-up");
  chk_rom_after_warm: assert property (rom_read_out |-> por_cnt_q >= POR_WARMUP_CYCLES)
    else $error("configuration read before warm-up ended");
  chk_rom_last_six: assert property (rom_read_out |-> rom_addr_out >= ROM_LAST_ADDR - 14'h0005)
    else $error("configuration read outside last six bytes");
  chk_swr_reset: assert property (sw_wr && pwdata_in[7:0] == 8'h56 |=> chip_reset_out)
    else $error("software reset code did not reset the chip");
  chk_reset_hold: assert property ($rose(chip_reset_out) |-> chip_reset_out [*5])
    else $error("chip reset pulse too short");
  chk_level_copy: assert property (!chip_reset_out |-> supply_ctl_out.undervolt_reset_level == cfg_q[5:2])
    else $error("undervolt reset level differs from loaded byte");
  chk_por_halt_off: assert property (low_pwr && $past(low_pwr) |-> !supply_ctl_out.power_on_detect_on)
    else $error("power-on detection on in Halt or Stop");
  chk_detect_idle_off: assert property (not_run && $past(not_run) |-> !supply_ctl_out.undervolt_detect_on)
    else $error("undervolt detection on outside run modes");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  cov_sw_reset: cover property (sw_wr && pwdata_in[7:0] == 8'h56);
  cov_rom_read: cover property (rom_read_out && rom_addr_out == ROM_LAST_ADDR);
  cov_release: cover property ($fell(chip_reset_out));
endmodule
bind rvsup_top rvsup_props #(.POR_WARMUP_CYCLES(POR_WARMUP_CYCLES), .ROM_LAST_ADDR(ROM_LAST_ADDR)) u_props (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
  .cpu_mode_in(cpu_mode_in), .rom_read_out(rom_read_out), .rom_addr_out(rom_addr_out),
  .rom_data_in(rom_data_in), .chip_reset_out(chip_reset_out), .supply_ctl_out(supply_ctl_out));

// File: testbench/rvsup_top_bench.sv
/*
  Self-checking bench of the reset and voltage supervisor.
  Assumes zero-wait APB answers and the shortened warm-up and watchdog counts.
*/
`timescale 1ns/1ps
module rvsup_top_bench;
  logic clock_in, sys_rst_in, psel_in, penable_in, pwrite_in, pin_reset_n_in;
  logic undervolt_reset_trip_in, undervolt_detect_trip_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, rom_read_out, chip_reset_out;
  logic [13:0] rom_addr_out;
  logic [7:0] rom_data_in, lfsr_q;
  rvsup_pkg::rvsup_mode_t cpu_mode_in;
  rvsup_pkg::rvsup_supply_t supply_ctl_out;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int fail_count = 0, total_checks = 0;
  rvsup_top #(.POR_WARMUP_CYCLES(20), .WDT_MAX_CYCLES(64), .ROM_LAST_ADDR(14'h3fff)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .cpu_mode_in(cpu_mode_in),
    .pin_reset_n_in(pin_reset_n_in), .undervolt_reset_trip_in(undervolt_reset_trip_in),
    .undervolt_detect_trip_in(undervolt_detect_trip_in),
    .power_on_trip_in(1'b0), .rom_read_out(rom_read_out), .rom_addr_out(rom_addr_out),
    .rom_data_in(rom_data_in), .chip_reset_out(chip_reset_out), .supply_ctl_out(supply_ctl_out));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // ==========================================================
  // Configuration ROM: high byte enables pin reset, level 0111
  always @(posedge clock_in) begin
    rom_data_in <= (rom_addr_out == 14'h3fff) ? 8'h5c : {2'h0, rom_addr_out[5:0]};
  end
  // ==========================================================
  // Answer monitor
  always @(posedge clock_in) begin
    if (pready_out === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      total_checks++;
      if (pslverr_out !== e[32] || (e[33] && prdata_out !== e[31:0])) begin
        fail_count++;
        $display("BAD t=%0t got=%h/%h exp=%h/%h", $time, pslverr_out, prdata_out, e[32], e[31:0]);
      end
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] x);
    int n;
    n = 0;
    exp_q.push_back({~w, err, x});
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (pready_out !== 1'b1) begin
      fail_count++;
      $display("BAD t=%0t no ready for %h", $time, a);
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    // Second edge lets outputs launched by the access settle before any check
    repeat (2) @(posedge clock_in);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (chip_reset_out !== v && n < lim) begin
      @(posedge clock_in);
      n++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    fail_count++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    pin_reset_n_in = 1'b1;
    undervolt_reset_trip_in = 1'b0;
    undervolt_detect_trip_in = 1'b0;
    cpu_mode_in = rvsup_pkg::RVSUP_FAST;
    lfsr_q = 8'h73;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    chk(chip_reset_out, 1'b1);
    wait_rst(1'b0, 200);
    chk(chip_reset_out, 1'b0);
    apb(1'b0, 12'h3f8, 0, 1'b0, 32'h0000_005c);
    chk(supply_ctl_out.undervolt_reset_level, 4'h7);
    apb(1'b0, 12'h2fc, 0, 1'b0, 32'h0000_0000);
    apb(1'b0, 12'h3e0, 0, 1'b0, 32'h0000_0000);
    apb(1'b0, 12'h004, 0, 1'b1, 32'h0000_0000);
    $display("boot and defaults done");
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      apb(1'b1, 12'h2fc, {28'h0, lfsr_q[3:0]}, 1'b0, 0);
      apb(1'b0, 12'h2fc, 0, 1'b0, {28'h0, lfsr_q[3:0]});
      chk(supply_ctl_out.undervolt_detect_level, lfsr_q[3:0]);
    end
    apb(1'b1, 12'h2fc, 32'h0000_0080, 1'b0, 0);
    chk(supply_ctl_out.undervolt_detect_on, 1'b0);
    undervolt_detect_trip_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    apb(1'b0, 12'h2fc, 0, 1'b0, 32'h0000_0080);
    apb(1'b1, 12'h2fc, 32'h0000_000f, 1'b0, 0);
    repeat (4) @(posedge clock_in);
    apb(1'b0, 12'h2fc, 0, 1'b0, 32'h0000_004f);
    chk(supply_ctl_out.undervolt_detect_on, 1'b1);
    undervolt_detect_trip_in <= 1'b0;
    apb(1'b1, 12'h3e0, 32'h0000_0008, 1'b0, 0);
    chk(supply_ctl_out.undervolt_reset_on, 1'b0);
    apb(1'b1, 12'h3e0, 32'h0000_0000, 1'b0, 0);
    chk(supply_ctl_out.undervolt_reset_on, 1'b1);
    $display("supply controls done");
    apb(1'b1, 12'h25c, 32'h0000_0055, 1'b0, 0);
    repeat (4) @(posedge clock_in);
    chk(chip_reset_out, 1'b0);
    apb(1'b0, 12'h25c, 0, 1'b0, 32'h0000_0000);
    apb(1'b1, 12'h25c, 32'h0000_0056, 1'b0, 0);
    chk(chip_reset_out, 1'b1);
    wait_rst(1'b0, 50);
    apb(1'b0, 12'h2fc, 0, 1'b0, 32'h0000_0000);
    apb(1'b0, 12'h3f4, 0, 1'b0, 32'h0000_0004);
    $display("software reset done");
    pin_reset_n_in <= 1'b0;
    @(posedge clock_in);
    pin_reset_n_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    chk(chip_reset_out, 1'b0);
    pin_reset_n_in <= 1'b0;
    wait_rst(1'b1, 12);
    chk(chip_reset_out, 1'b1);
    pin_reset_n_in <= 1'b1;
    wait_rst(1'b0, 20);
    chk(chip_reset_out, 1'b0);
    apb(1'b0, 12'h3f4, 0, 1'b0, 32'h0000_0002);
    undervolt_reset_trip_in <= 1'b1;
    wait_rst(1'b1, 12);
    chk(chip_reset_out, 1'b1);
    undervolt_reset_trip_in <= 1'b0;
    wait_rst(1'b0, 20);
    apb(1'b0, 12'h3f4, 0, 1'b0, 32'h0000_0010);
    $display("pin and undervolt resets done");
    apb(1'b1, 12'h250, 32'h0000_0030, 1'b0, 0);
    cpu_mode_in <= rvsup_pkg::RVSUP_IDLE;
    apb(1'b1, 12'h3e0, 32'h0000_0080, 1'b0, 0);
    apb(1'b1, 12'h3dc, 32'h0000_00a0, 1'b0, 0);
    repeat (15) @(posedge clock_in);
    chk(supply_ctl_out.power_saving, 1'b1);
    chk(supply_ctl_out.undervolt_reset_on, 1'b0);
    cpu_mode_in <= rvsup_pkg::RVSUP_HALT;
    repeat (15) @(posedge clock_in);
    chk(chip_reset_out, 1'b0);
    chk(supply_ctl_out.power_on_detect_on, 1'b0);
    cpu_mode_in <= rvsup_pkg::RVSUP_SLOW;
    repeat (6) @(posedge clock_in);
    chk(chip_reset_out, 1'b0);
    wait_rst(1'b1, 8);
    chk(chip_reset_out, 1'b1);
    wait_rst(1'b0, 20);
    apb(1'b0, 12'h3f4, 0, 1'b0, 32'h0000_0008);
    repeat (80) @(posedge clock_in);
    chk(chip_reset_out, 1'b0);
    $display("watchdog done");
    complete_run();
  end
endmodule

// File: verilog/rvsup_pkg.sv
/*
  Constants, types and the register map of the reset and voltage supervisor.
  Assumes a 10 MHz supervisor clock and 32-bit APB with one register per aligned word.
*/
package rvsup_pkg;

  // ==========================================================
  // Clock and timing
  localparam longint CLK_HZ = 10_000_000;
  localparam longint POR_WARMUP_MS = 40;
  localparam int unsigned POR_WARMUP_CYC = int'((POR_WARMUP_MS * CLK_HZ) / 1000);
  localparam longint WDT_PERIOD_MAX_MS = 240;
  localparam int unsigned WDT_MAX_CYC = int'((WDT_PERIOD_MAX_MS * CLK_HZ) / 1000);
  localparam int unsigned PIN_RESET_MIN_CYC = 2;
  localparam int unsigned RESET_HOLD_CYC = 4;

  // ==========================================================
  // Configuration ROM
  localparam logic [13:0] ROM_LAST_ADDR = 14'h3fff;
  localparam int unsigned CFG_BYTES = 6;
  localparam int unsigned CFG_PIN_RST_EN_BIT = 6;
  localparam int unsigned CFG_LVR_LEVEL_LSB = 2;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [9:0] IDX_PRESCALE = 10'h094;
  localparam logic [9:0] IDX_SOFTWARE_COMMAND = 10'h097;
  localparam logic [9:0] IDX_VOLTAGE_DETECT_CONTROL = 10'h0bf;
  localparam logic [9:0] IDX_AUXILIARY_CONTROL_TWO = 10'h0f7;
  localparam logic [9:0] IDX_AUXILIARY_CONTROL_ONE = 10'h0f8;
  localparam logic [9:0] IDX_RESET_CAUSE = 10'h0fd;
  localparam logic [9:0] IDX_CONFIG_WORD_HIGH = 10'h0fe;

  // ==========================================================
  // Field positions and codes
  localparam logic [7:0] SOFTWARE_RESET_CODE = 8'h56;
  localparam int unsigned PSC_LSB = 4;
  localparam int unsigned DET_OFF_BIT = 7;
  localparam int unsigned DET_FLAG_BIT = 6;
  localparam int unsigned WDT_EN_LSB = 6;
  localparam int unsigned POWER_SAVING_BIT = 5;
  localparam int unsigned WDT_CLEAR_BIT = 7;
  localparam int unsigned LVR_OFF_BIT = 3;
  localparam logic [1:0] WDT_EN_RUN_ONLY = 2'h2;
  localparam logic [1:0] WDT_EN_ALWAYS = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [3:0] DET_LEVEL_RST = 4'h0;
  localparam logic [1:0] PSC_RST = 2'h0;
  localparam logic [1:0] WDT_EN_RST = 2'h0;
  localparam logic [7:0] CFG_BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    RVSUP_FAST,
    RVSUP_SLOW,
    RVSUP_IDLE,
    RVSUP_HALT,
    RVSUP_STOP
  } rvsup_mode_t;

  typedef enum logic [1:0] {
    RVSUP_WARMUP,
    RVSUP_LOAD,
    RVSUP_RUN
  } rvsup_state_t;

  // Controls toward the analog supply monitors
  typedef struct packed {
    logic undervolt_reset_on;
    logic power_on_detect_on;
    logic undervolt_detect_on;
    logic power_saving;
    logic [3:0] undervolt_reset_level;
    logic [3:0] undervolt_detect_level;
  } rvsup_supply_t;

  // Reset cause bits: por, pin, software, watchdog, undervolt
  typedef struct packed {
    logic undervolt;
    logic watchdog;
    logic software;
    logic pin;
    logic power_on;
  } rvsup_cause_t;

endpackage

// File: verilog/rvsup_top.sv
/*
  Reset and voltage supervisor: merges five reset sources into the chip reset,
  runs the warm-up and configuration load, the watchdog and the supply monitor controls.
  Assumes APB3 master on clock_in, ROM data one cycle after the address, analog trip
  inputs asynchronous to clock_in, and the mode input from logic on clock_in.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Chip reset merges power-on, pin, software, watchdog and undervolt resets.
// - Every reset returns all registers to their default values; the reset cause and loaded config bytes keep their values through a chip reset.
// - After power-on, hold the chip in reset for 40 ms warm-up.
// - After warm-up, load configuration from the last six ROM bytes.
// - Power-on detection is switched off in Halt and Stop.
// - Pin reset is active low and must stay low two clock cycles.
// - Pin reset counts only when the loaded pin-reset enable bit is set.
// - Loaded high config byte bits 5..2 select the undervolt reset level.
// - Writing 56h to the software command register resets the chip.
// - Watchdog reset is enabled by a field in auxiliary register two.
// - Watchdog counts on the supervisor clock.
// - Watchdog runs in Fast/Slow; in low-power modes only when always enabled.
// - Prescale field selects the watchdog overflow period.
// - Watchdog counter clears on any reset and on the clear bit.
// - Undervolt reset off bit: 0 enables, 1 disables; resets to 0.
// - Detect off bit: 0 enables, 1 disables; off in Idle, Halt, Stop.
// - Detect register bit 6 shows the detector output, read only.
// - Four-bit detect level: 0000 lowest, 1111 highest.
// - Power-saving bit reduces consumption in Idle, Halt and Stop.
// - Power saving in Idle or reset-off bit swaps to power-on; Halt/Stop both off.
// - Watchdog enable: 0x off, 10 Fast/Slow only, 11 always.
// - Prescale 00 240 ms, 01 120 ms, 10 60 ms, 11 30 ms.
// - Watchdog clear bit self-clears on the next cycle.
module rvsup_top #(
  parameter int unsigned POR_WARMUP_CYCLES = rvsup_pkg::POR_WARMUP_CYC,
  parameter int unsigned WDT_MAX_CYCLES = rvsup_pkg::WDT_MAX_CYC,
  parameter logic [13:0] ROM_LAST_ADDR = rvsup_pkg::ROM_LAST_ADDR
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rvsup_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input rvsup_pkg::rvsup_mode_t cpu_mode_in,
  input wire logic pin_reset_n_in,
  input wire logic undervolt_reset_trip_in,
  input wire logic undervolt_detect_trip_in,
  input wire logic power_on_trip_in,
  output logic rom_read_out,
  output logic [13:0] rom_addr_out,
  input wire logic [7:0] rom_data_in,
  output logic chip_reset_out,
  output rvsup_pkg::rvsup_supply_t supply_ctl_out
);

  localparam int WARM_W = $clog2(POR_WARMUP_CYCLES + 1);
  localparam int WDT_W = $clog2(WDT_MAX_CYCLES + 1);

  // ==========================================================
  // Input synchronisers: bit 0 pin, 1 reset trip, 2 detect trip, 3 power-on trip
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] filt_q;
  logic [3:0] raw_in;
  logic [3:0] filt_d;
  assign raw_in = {power_on_trip_in, undervolt_detect_trip_in, undervolt_reset_trip_in, pin_reset_n_in};
  assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync1_q <= 4'h1;
      sync2_q <= 4'h1;
      sync3_q <= 4'h1;
      filt_q <= 4'h1;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // ==========================================================
  // State, registers
  rvsup_pkg::rvsup_state_t state_q;
  rvsup_pkg::rvsup_state_t state_d;
  logic [WARM_W-1:0] warm_cnt_q;
  logic [2:0] load_idx_q;
  logic cap_q;
  logic [2:0] cap_idx_q;
  logic [7:0] cfg_mem_q [rvsup_pkg::CFG_BYTES];
  logic [WDT_W-1:0] wdt_cnt_q;
  logic [1:0] pin_low_q;
  logic [2:0] hold_q;
  logic chip_rst_q;
  logic [1:0] psc_q;
  logic det_off_q;
  logic [3:0] det_level_q;
  logic det_flag_q;
  logic [1:0] wdt_en_q;
  logic power_saving_q;
  logic wdt_clear_q;
  logic lvr_off_q;
  rvsup_pkg::rvsup_cause_t cause_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rom_read_q;
  logic [13:0] rom_addr_q;
  rvsup_pkg::rvsup_supply_t supply_q;

  // Registers return to defaults on power-on and on any chip reset
  logic reg_rst;
  assign reg_rst = sys_rst_in | chip_rst_q;

  // ==========================================================
  // Mode decode and supply monitor enables
  logic run_mode;
  logic idle_mode;
  logic deep_mode;
  assign run_mode = (cpu_mode_in == rvsup_pkg::RVSUP_FAST) | (cpu_mode_in == rvsup_pkg::RVSUP_SLOW);
  assign idle_mode = (cpu_mode_in == rvsup_pkg::RVSUP_IDLE);
  assign deep_mode = (cpu_mode_in == rvsup_pkg::RVSUP_HALT) | (cpu_mode_in == rvsup_pkg::RVSUP_STOP);

  logic swap_to_por;
  logic lvr_on;
  logic por_on;
  logic det_on;
  assign swap_to_por = lvr_off_q | (power_saving_q & ~run_mode);
  assign lvr_on = ~swap_to_por & (~deep_mode | ~power_saving_q);
  assign por_on = ~deep_mode;
  assign det_on = ~det_off_q & run_mode;

  logic [7:0] cfg_high;
  assign cfg_high = cfg_mem_q[rvsup_pkg::CFG_BYTES-1];

  // ==========================================================
  // Reset sources
  logic pin_en;
  logic pin_hit;
  logic lvr_hit;
  logic por_hit;
  assign pin_en = cfg_high[rvsup_pkg::CFG_PIN_RST_EN_BIT];
  assign pin_hit = pin_en & (pin_low_q >= 2'(rvsup_pkg::PIN_RESET_MIN_CYC));
  assign lvr_hit = lvr_on & filt_q[1];
  assign por_hit = por_on & filt_q[3];

  // ==========================================================
  // APB decode
  logic [9:0] idx;
  logic setup_ph;
  logic wr_en;
  logic hit_psc;
  logic hit_cmd;
  logic hit_det;
  logic hit_auxiliary_control_two;
  logic hit_auxiliary_control_one;
  logic hit_cause;
  logic hit_cfg;
  logic mapped;
  assign idx = paddr_in[rvsup_pkg::APB_ADDR_W-1:2];
  assign setup_ph = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & pready_q & pwrite_in & ~pslverr_q;
  assign hit_psc = (idx == rvsup_pkg::IDX_PRESCALE);
  assign hit_cmd = (idx == rvsup_pkg::IDX_SOFTWARE_COMMAND);
  assign hit_det = (idx == rvsup_pkg::IDX_VOLTAGE_DETECT_CONTROL);
  assign hit_auxiliary_control_two = (idx == rvsup_pkg::IDX_AUXILIARY_CONTROL_TWO);
  assign hit_auxiliary_control_one = (idx == rvsup_pkg::IDX_AUXILIARY_CONTROL_ONE);
  assign hit_cause = (idx == rvsup_pkg::IDX_RESET_CAUSE);
  assign hit_cfg = (idx == rvsup_pkg::IDX_CONFIG_WORD_HIGH);
  assign mapped = (paddr_in[1:0] == 2'h0) & (hit_psc | hit_cmd | hit_det | hit_auxiliary_control_two | hit_auxiliary_control_one | hit_cause | hit_cfg);

  logic sw_hit;
  assign sw_hit = wr_en & hit_cmd & (pwdata_in[7:0] == rvsup_pkg::SOFTWARE_RESET_CODE);

  logic [7:0] rd_byte;
  assign rd_byte = ({8{hit_psc}} & {2'h0, psc_q, 4'h0})
                 | ({8{hit_det}} & {det_off_q, det_flag_q, 2'h0, det_level_q})
                 | ({8{hit_auxiliary_control_two}} & {wdt_en_q, power_saving_q, 5'h00})
                 | ({8{hit_auxiliary_control_one}} & {wdt_clear_q, 3'h0, lvr_off_q, 3'h0})
                 | ({8{hit_cause}} & {3'h0, cause_q})
                 | ({8{hit_cfg}} & cfg_high);

  // ==========================================================
  // Watchdog
  logic wdt_run;
  logic wdt_rst_en;
  logic [WDT_W-1:0] wdt_limit;
  logic wdt_ovf;
  assign wdt_run = run_mode | (wdt_en_q == rvsup_pkg::WDT_EN_ALWAYS);
  assign wdt_rst_en = (wdt_en_q == rvsup_pkg::WDT_EN_ALWAYS)
                    | ((wdt_en_q == rvsup_pkg::WDT_EN_RUN_ONLY) & run_mode);
  assign wdt_limit = WDT_W'(WDT_MAX_CYCLES >> psc_q);
  assign wdt_ovf = wdt_run & (wdt_cnt_q >= wdt_limit - WDT_W'(1));

  always_ff @(posedge clock_in) begin
    if (reg_rst | wdt_clear_q | wdt_ovf) begin
      wdt_cnt_q <= '0;
    end else if (wdt_run) begin
      wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);
    end
  end

  // ==========================================================
  // Chip reset merge and stretch
  logic event_now;
  logic chip_rst_d;
  assign event_now = sw_hit | (wdt_ovf & wdt_rst_en) | pin_hit | lvr_hit;
  assign chip_rst_d = (state_q != rvsup_pkg::RVSUP_RUN) | por_hit | event_now | (hold_q != 3'h0);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      chip_rst_q <= 1'b1;
      hold_q <= 3'h0;
      pin_low_q <= 2'h0;
    end else begin
      chip_rst_q <= chip_rst_d;
      if (event_now) begin
        hold_q <= 3'(rvsup_pkg::RESET_HOLD_CYC);
      end else if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end
      if (filt_q[0]) begin
        pin_low_q <= 2'h0;
      end else if (pin_low_q != 2'h3) begin
        pin_low_q <= pin_low_q + 2'h1;
      end
    end
  end

  // Cause survives chip reset; only power-on clears it
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cause_q <= 5'h01;
    end else if (~chip_rst_q & chip_rst_d) begin
      cause_q <= {lvr_hit, wdt_ovf & wdt_rst_en, sw_hit, pin_hit, por_hit};
    end
  end

  // ==========================================================
  // Warm-up and configuration load
  always_comb begin
    state_d = state_q;
    case (state_q)
      rvsup_pkg::RVSUP_WARMUP: begin
        if (warm_cnt_q >= WARM_W'(POR_WARMUP_CYCLES - 1)) begin
          state_d = rvsup_pkg::RVSUP_LOAD;
        end
      end
      rvsup_pkg::RVSUP_LOAD: begin
        if (cap_q & (cap_idx_q == 3'(rvsup_pkg::CFG_BYTES - 1))) begin
          state_d = rvsup_pkg::RVSUP_RUN;
        end
      end
      rvsup_pkg::RVSUP_RUN: begin
        state_d = rvsup_pkg::RVSUP_RUN;
      end
      default: begin
        state_d = rvsup_pkg::RVSUP_WARMUP;
      end
    endcase
    if (por_hit) begin
      state_d = rvsup_pkg::RVSUP_WARMUP;
    end
  end

  logic issue;
  assign issue = (state_q == rvsup_pkg::RVSUP_LOAD) & (load_idx_q < 3'(rvsup_pkg::CFG_BYTES)) & ~por_hit;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= rvsup_pkg::RVSUP_WARMUP;
      warm_cnt_q <= '0;
      load_idx_q <= 3'h0;
      cap_q <= 1'b0;
      cap_idx_q <= 3'h0;
      rom_read_q <= 1'b0;
      rom_addr_q <= 14'h0000;
    end else begin
      state_q <= state_d;
      warm_cnt_q <= (state_q == rvsup_pkg::RVSUP_WARMUP) & ~por_hit ? warm_cnt_q + WARM_W'(1) : '0;
      load_idx_q <= issue ? load_idx_q + 3'h1 : (state_q == rvsup_pkg::RVSUP_LOAD ? load_idx_q : 3'h0);
      // ROM answers in the cycle after its read strobe
      cap_q <= rom_read_q;
      cap_idx_q <= load_idx_q - 3'h1;
      rom_read_q <= issue;
      rom_addr_q <= ROM_LAST_ADDR - 14'(rvsup_pkg::CFG_BYTES - 1) + 14'(issue ? load_idx_q : 3'h0);
    end
  end

  for (genvar i = 0; i < rvsup_pkg::CFG_BYTES; i++) begin : g_cfg
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        cfg_mem_q[i] <= rvsup_pkg::CFG_BYTE_RST;
      end else if (cap_q & (cap_idx_q == 3'(i)) & ~por_hit) begin
        cfg_mem_q[i] <= rom_data_in;
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clock_in) begin
    if (reg_rst) begin
      psc_q <= rvsup_pkg::PSC_RST;
      det_off_q <= 1'b0;
      det_level_q <= rvsup_pkg::DET_LEVEL_RST;
      wdt_en_q <= rvsup_pkg::WDT_EN_RST;
      power_saving_q <= 1'b0;
      wdt_clear_q <= 1'b0;
      lvr_off_q <= 1'b0;
    end else begin
      wdt_clear_q <= wr_en & hit_auxiliary_control_one & pwdata_in[rvsup_pkg::WDT_CLEAR_BIT];
      if (wr_en & hit_psc) begin
        psc_q <= pwdata_in[rvsup_pkg::PSC_LSB +: 2];
      end
      if (wr_en & hit_det) begin
        det_off_q <= pwdata_in[rvsup_pkg::DET_OFF_BIT];
        det_level_q <= pwdata_in[3:0];
      end
      if (wr_en & hit_auxiliary_control_two) begin
        wdt_en_q <= pwdata_in[rvsup_pkg::WDT_EN_LSB +: 2];
        power_saving_q <= pwdata_in[rvsup_pkg::POWER_SAVING_BIT];
      end
      if (wr_en & hit_auxiliary_control_one) begin
        lvr_off_q <= pwdata_in[rvsup_pkg::LVR_OFF_BIT];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reg_rst) begin
      det_flag_q <= 1'b0;
    end else begin
      det_flag_q <= det_on & filt_q[2];
    end
  end

  // ==========================================================
  // APB answer: pready rises in the first access cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        prdata_q <= {24'h00_0000, rd_byte};
        pslverr_q <= ~mapped;
      end
    end
  end

  // ==========================================================
  // Supply controls
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      supply_q <= '0;
    end else begin
      supply_q.undervolt_reset_on <= lvr_on;
      supply_q.power_on_detect_on <= por_on;
      supply_q.undervolt_detect_on <= det_on;
      supply_q.power_saving <= power_saving_q & ~run_mode;
      supply_q.undervolt_reset_level <= cfg_high[rvsup_pkg::CFG_LVR_LEVEL_LSB +: 4];
      supply_q.undervolt_detect_level <= det_level_q;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign rom_read_out = rom_read_q;
  assign rom_addr_out = rom_addr_q;
  assign chip_reset_out = chip_rst_q;
  assign supply_ctl_out = supply_q;

endmodule
